/* File: dv/plld_far_model.sv */
// far side model: loop edge source and serial read port
`timescale 1ns/100ps
`default_nettype none
module plld_far_model
(
  input  wire logic clk_i,
  output logic      ref_o = 1'b0,
  output logic      vco_o = 1'b0,
  output logic      act_o = 1'b0,
  output logic      sd_o  = 1'b0
);
  // one comparison, trailing edge gap cycles after the leading one
  // edges come at most every 5 cycles, far under 50 MHz
  task automatic pair(input int gap, input logic vco_first);
    @(posedge clk_i);
    ref_o <= !vco_first || gap == 0;
    vco_o <= vco_first || gap == 0;
    for (int i = 0; i < gap; i++)
    begin
      @(posedge clk_i);
      ref_o <= vco_first && i == gap - 1;
      vco_o <= !vco_first && i == gap - 1;
    end
    @(posedge clk_i);
    ref_o <= 1'b0;
    vco_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // data line outside a read shows the inverse of its last value
  task automatic serial(input logic act, input logic b);
    @(posedge clk_i);
    act_o <= act;
    sd_o  <= act ? b : !sd_o;
  endtask
endmodule
`default_nettype wire

/* File: dv/plld_lock_detector_asserts.sv */
// port assertions for the lock detector
`timescale 1ns/100ps
`default_nettype none
module plld_lock_detector_asserts
  import plld_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              CE_I,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [31:0]       DAT_O,
  input wire logic              ACK_O,
  input wire logic              REF_EDGE_I,
  input wire logic              VCO_EDGE_I,
  input wire logic              SERIAL_READ_ACTIVE_I,
  input wire logic              SERIAL_DATA_I,
  input wire logic              LOCK_OR_SERIAL_OUT_PIN_O,
  input wire logic              GPO_LOCK_TIMER_CLK_O,
  input wire logic              LOCK_O,
  input wire logic              IRQ_O
);
  wire edg = REF_EDGE_I | VCO_EDGE_I;
  wire wra = ACK_O & WE_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_lock_rise_cause: assert property (
    $rose(LOCK_O) |-> $past(edg) || $past(edg, 2) || $past(edg, 3))
    else $error("lock rose with no comparison");
  a_lock_fall_cause: assert property (
    $fell(LOCK_O) |-> $past(edg) || $past(edg, 2) || $past(edg, 3)
      || $past(wra) || $past(wra, 2) || $past(wra, 3))
    else $error("lock fell with no miss or disable");
  a_pin_source: assert property (
    LOCK_OR_SERIAL_OUT_PIN_O |-> LOCK_O
      || ($past(SERIAL_READ_ACTIVE_I) && $past(SERIAL_DATA_I)))
    else $error("shared pin high without lock or serial data");
  a_status_read: assert property (
    ACK_O && !WE_I && ADR_I == {STATUS_IDX, 2'b00}
      |-> DAT_O[31:2] == 30'h0 && !DAT_O[0]
      && (DAT_O[1] == LOCK_O || DAT_O[1] == $past(LOCK_O)))
    else $error("status word does not match lock");
  a_timer_high: assert property (
    disable iff (!RESET_N_I || !CE_I)
    $rose(GPO_LOCK_TIMER_CLK_O) |-> ##[1:8] !GPO_LOCK_TIMER_CLK_O)
    else $error("timer clock high too long");
  a_reset_quiet: assert property (
    $rose(RESET_N_I) |-> !LOCK_O && !IRQ_O && !ACK_O)
    else $error("outputs active after reset");
  a_ack_next: assert property (
    CYC_I && STB_I && CE_I && !ACK_O |=> ACK_O)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_irq_cause: assert property (
    $rose(IRQ_O) |-> $changed(LOCK_O) || $past(LOCK_O) != $past(LOCK_O, 2)
      || $past(LOCK_O, 2) != $past(LOCK_O, 3) || $past(wra) || $past(wra, 2))
    else $error("interrupt rose without event or write");
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the lock detector
`timescale 1ns/100ps
`default_nettype none
module tb;
  import plld_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [9:0]  adr   = '0;
  logic [31:0] wd    = '0;
  logic        ce    = 1'b1;
  logic [31:0] dat;
  logic [31:0] rd;
  logic        ack;
  logic        pin;
  logic        gpo;
  logic        lock;
  logic        irq;
  wire         ref_e;
  wire         vco_e;
  wire         s_act;
  wire         s_dat;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          w;
  int          n;
  int          tgt [8]     = '{5, 32, 96, 256, 512, 2048, 8192, 65535};

  always #12.5 clk = ~clk;

  plld_lock_detector plld_lock_detector_inst (
    .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wd), .DAT_O(dat), .ACK_O(ack),
    .REF_EDGE_I(ref_e), .VCO_EDGE_I(vco_e), .SERIAL_READ_ACTIVE_I(s_act),
    .SERIAL_DATA_I(s_dat), .LOCK_OR_SERIAL_OUT_PIN_O(pin),
    .GPO_LOCK_TIMER_CLK_O(gpo), .LOCK_O(lock), .IRQ_O(irq));
  plld_far_model far_inst (
    .clk_i(clk), .ref_o(ref_e), .vco_o(vco_e), .act_o(s_act), .sd_o(s_dat));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= wr;
    adr <= {idx, 2'b00};
    wd  <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20)
      chk("ack", 32'h1, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input string nm);
    wb(idx, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask

  // counts edges while the timer clock holds v
  task automatic lvl(input logic v);
    n = 0;
    while (gpo === v && n < 20)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    idle(8);
    rst_n <= 1'b1;
    chk("lock at reset", 0, lock);
    rdc(LOCK_CFG_IDX, 32'h14D, "lock cfg");
    rdc(PIN_CFG_IDX, 32'h1, "pin cfg");
    rdc(STATUS_IDX, 32'h0, "status");
    wb(8'hFF, 1'b1, 32'hFFFFFFFF);
    rdc(8'hFF, 32'h0, "unmapped");
    wb(IRQ_ENABLE_IDX, 1'b1, 32'h3);
    $display("test reset done");
    for (int c = 0; c < 7; c++)
    begin
      wb(LOCK_CFG_IDX, 1'b1, 32'h0);
      idle(2);
      chk("lock off", 0, lock);
      wb(LOCK_CFG_IDX, 1'b1, {28'h0, 1'b1, c[2:0]});
      repeat (tgt[c] - 1) far_inst.pair(0, 1'b0);
      chk("early lock", 0, lock);
      far_inst.pair(0, 1'b1);
      chk("lock count", 1, lock);
    end
    $display("test count done");
    rdc(STATUS_IDX, 32'h2, "status lock");
    chk("pin lock", 1, pin);
    far_inst.serial(1'b1, 1'b0);
    idle(2);
    chk("pin serial", 0, pin);
    far_inst.serial(1'b0, 1'b0);
    idle(2);
    chk("pin back", 1, pin);
    wb(PIN_CFG_IDX, 1'b1, 32'h41);
    far_inst.serial(1'b1, 1'b0);
    idle(2);
    chk("pin shared", 1, pin);
    far_inst.serial(1'b0, 1'b0);
    wb(PIN_CFG_IDX, 1'b1, 32'h0);
    idle(2);
    chk("pin off", 0, pin);
    wb(IRQ_CLEAR_IDX, 1'b1, 32'h3);
    idle(2);
    chk("irq cleared", 0, irq);
    wb(IRQ_ENABLE_IDX, 1'b1, 32'h1);
    far_inst.pair(1, 1'b0);
    chk("miss lock", 0, lock);
    chk("irq masked", 0, irq);
    rdc(IRQ_STATUS_IDX, 32'h2, "irq status");
    wb(IRQ_ENABLE_IDX, 1'b1, 32'h3);
    idle(2);
    chk("irq raised", 1, irq);
    wb(IRQ_CLEAR_IDX, 1'b1, 32'h2);
    idle(2);
    chk("irq clear", 0, irq);
    $display("test pin irq done");
    for (int d = 0; d < 8; d++)
    begin
      w = (d == 0 ? 1 : 1 << d) << (d % 4);
      wb(LOCK_CFG_IDX, 1'b1, 32'h0);
      // the timer copy lags the disable by two edges
      idle(3);
      chk("timer idle", 0, gpo);
      wb(LOCK_CFG_IDX, 1'b1, {20'h0, d[1:0], d[2:0], 7'h48});
      for (int i = 0; i < 5; i++) far_inst.pair(w - 1, i[0]);
      chk("window lock", 1, lock);
      far_inst.pair(w, 1'b1);
      chk("window miss", 0, lock);
      lvl(1'b1);
      lvl(1'b0);
      lvl(1'b1);
      chk("timer half", 32'(1 << (d % 4)), 32'(n));
    end
    // clock enable low must freeze the timer output
    ce <= 1'b0;
    idle(1);
    lvl(gpo);
    chk("timer frozen", 32'd20, 32'(n));
    ce <= 1'b1;
    $display("test window done");
    give_verdict();
  end

  initial
  begin
    idle(90000);
    n_fail++;
    give_verdict();
  end
endmodule

bind plld_lock_detector plld_lock_detector_asserts plld_lock_detector_asserts_inst (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .REF_EDGE_I(REF_EDGE_I), .VCO_EDGE_I(VCO_EDGE_I),
  .SERIAL_READ_ACTIVE_I(SERIAL_READ_ACTIVE_I), .SERIAL_DATA_I(SERIAL_DATA_I),
  .LOCK_OR_SERIAL_OUT_PIN_O(LOCK_OR_SERIAL_OUT_PIN_O),
  .GPO_LOCK_TIMER_CLK_O(GPO_LOCK_TIMER_CLK_O), .LOCK_O(LOCK_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: logic/plld_lock_detector.sv */
// digital lock detector with wishbone registers and shared lock pin
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - enable bit gates every lock function
// - measure reference to divided edge gap
// - either edge may lead; magnitude only
// - lock after target consecutive in-window comparisons
// - window type clear: fixed window, 10 ns rounded up to one system cycle
// - window type set: timer cycles window
// - rate field selects lock-timer clock frequency
// - lock-timer clock on test output pin
// - lock flag readable in status bit 1
// - source select 1 drives lock on pin
// - serial read borrows pin, then lock returns
// - target codes 5 to 65535, reset 2048
// - duration codes half to 64, reset 2
module plld_lock_detector
  import plld_pkg::*;
(
  // clock, reset, enable
  input  wire logic              CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CE_I,
  // wishbone slave
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [ADDR_W-1:0] ADR_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic [31:0]       DAT_I,
  output logic [31:0]            DAT_O,
  output logic                   ACK_O,
  // phase comparator edges
  input  wire logic              REF_EDGE_I,
  input  wire logic              VCO_EDGE_I,
  // serial port read path
  input  wire logic              SERIAL_READ_ACTIVE_I,
  input  wire logic              SERIAL_DATA_I,
  // pins and interrupt
  output logic                   LOCK_OR_SERIAL_OUT_PIN_O,
  output logic                   GPO_LOCK_TIMER_CLK_O,
  output logic                   LOCK_O,
  output logic                   IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [RUN_W-1:0] run_target(input logic [CNT_TARGET_W-1:0] code);
    logic [RUN_W-1:0] t;
    t = 16'h0005;
    unique case (code)
      3'h0: t = 16'h0005;
      3'h1: t = 16'h0020;
      3'h2: t = 16'h0060;
      3'h3: t = 16'h0100;
      3'h4: t = 16'h0200;
      3'h5: t = 16'h0800;
      3'h6: t = 16'h2000;
      3'h7: t = 16'hFFFF;
    endcase
    return t;
  endfunction

  // window length in system cycles: timer half-cycles times half period
  function automatic logic [WIN_W-1:0] dig_window(input logic [WIN_DUR_W-1:0] dur,
                                                   input logic [LT_RATE_W-1:0] rate);
    logic [WIN_W-1:0] halves;
    halves = (dur == 3'h0) ? 11'h001 : WIN_W'(11'h002 << (dur - 3'h1));
    return WIN_W'(halves << rate);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wr & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [31:0]      lock_cfg;
  logic [31:0]      pin_cfg;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [RUN_W-1:0] run_cnt;
  logic             locked;

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  wire                    lock_en  = lock_cfg[LOCK_EN_BIT];
  wire                    win_dig  = lock_cfg[WIN_TYPE_BIT];
  wire [CNT_TARGET_W-1:0] tgt_code = lock_cfg[CNT_TARGET_LSB +: CNT_TARGET_W];
  wire [WIN_DUR_W-1:0]    dur_code = lock_cfg[WIN_DUR_LSB +: WIN_DUR_W];
  wire [LT_RATE_W-1:0]    lt_rate  = lock_cfg[LT_RATE_LSB +: LT_RATE_W];
  wire [PIN_SRC_W-1:0]    pin_src  = pin_cfg[PIN_SRC_LSB +: PIN_SRC_W];
  wire                    pin_share = pin_cfg[PIN_SHARE_BIT];

  wire [RUN_W-1:0] target = run_target(tgt_code);
  wire [WIN_W-1:0] ana_window = WIN_W'(ANA_WIN_CYC);
  wire [WIN_W-1:0] window = win_dig ? dig_window(dur_code, lt_rate)
                                    : ana_window;

  ////////////////////////////////////////////////////////////////////////////
  // lock timer and comparator

  wire lt_clk;
  wire cmp_done;
  wire cmp_inside;

  plld_lock_timer u_timer
  (
    .clk_i    (CLK_I),
    .rst_n_i  (RESET_N_I),
    .ce_i     (CE_I),
    .run_i    (lock_en),
    .rate_i   (lt_rate),
    .lt_clk_o (lt_clk)
  );

  plld_phase_cmp u_cmp
  (
    .clk_i      (CLK_I),
    .rst_n_i    (RESET_N_I),
    .ce_i       (CE_I),
    .run_i      (lock_en),
    .window_i   (window),
    .ref_edge_i (REF_EDGE_I),
    .vco_edge_i (VCO_EDGE_I),
    .done_o     (cmp_done),
    .inside_o   (cmp_inside)
  );

  ////////////////////////////////////////////////////////////////////////////
  // consecutive run counter and lock flag

  wire             hit       = cmp_done && cmp_inside;
  wire             miss      = cmp_done && !cmp_inside;
  // saturate so a held lock never wraps the run back to zero
  wire [RUN_W-1:0] run_inc   = (run_cnt == target) ? run_cnt : run_cnt + 1'b1;
  wire [RUN_W-1:0] next_run  = (!lock_en || miss) ? '0 : (hit ? run_inc : run_cnt);
  wire             next_lock = lock_en && !miss && (locked || (hit && run_inc >= target));
  wire             gained    = next_lock && !locked;
  wire             lost      = locked && !next_lock;

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      run_cnt <= '0;
    else if (CE_I)
      run_cnt <= next_run;
  end

  // lock changes one edge after the comparison that decides it
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      locked <= 1'b0;
    else if (CE_I)
      locked <= next_lock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  wire [7:0] idx       = ADR_I[ADDR_W-1:2];
  wire       req       = CYC_I && STB_I;
  wire       wr_commit = req && WE_I && ACK_O;
  wire       req_new   = req && !ACK_O;
  wire       sel_lock  = (idx == LOCK_CFG_IDX);
  wire       sel_pin   = (idx == PIN_CFG_IDX);
  wire       sel_stat  = (idx == STATUS_IDX);
  wire       sel_ists  = (idx == IRQ_STATUS_IDX);
  wire       sel_iclr  = (idx == IRQ_CLEAR_IDX);
  wire       sel_ien   = (idx == IRQ_ENABLE_IDX);

  wire [31:0] status_word = 32'(locked) << STATUS_LOCK_BIT;
  wire [31:0] rd_word = sel_lock ? lock_cfg :
                        sel_pin  ? pin_cfg :
                        sel_stat ? status_word :
                        sel_ists ? {30'h0, irq_status} :
                        sel_ien  ? {30'h0, irq_enable} : 32'h00000000;

  // reserved bits are masked so they always read back zero
  wire [31:0]      wr_lock = merge(lock_cfg, DAT_I, SEL_I) & LOCK_CFG_MASK;
  wire [31:0]      wr_pin  = merge(pin_cfg, DAT_I, SEL_I) & PIN_CFG_MASK;
  wire [IRQ_W-1:0] clr_bits = (wr_commit && sel_iclr && SEL_I[0]) ? DAT_I[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] evt_bits = {lost, gained};
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~clr_bits) | evt_bits;

  // one wait state: ack in the cycle after the request is seen
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      ACK_O <= 1'b0;
    else if (CE_I)
      ACK_O <= req_new;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      DAT_O <= 32'h00000000;
    else if (CE_I && req_new)
      DAT_O <= rd_word;
  end

  // writes land on the ack edge, again every second cycle while a request is held
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      lock_cfg <= LOCK_CFG_RESET;
    else if (CE_I && wr_commit && sel_lock)
      lock_cfg <= wr_lock;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      pin_cfg <= PIN_CFG_RESET;
    else if (CE_I && wr_commit && sel_pin)
      pin_cfg <= wr_pin;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      irq_enable <= '0;
    else if (CE_I && wr_commit && sel_ien && SEL_I[0])
      irq_enable <= DAT_I[IRQ_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: events win over a clear in the same cycle

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      irq_status <= '0;
    else if (CE_I)
      irq_status <= next_irq_status;
  end

  // level output follows the status being stored on this edge
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      IRQ_O <= 1'b0;
    else if (CE_I)
      IRQ_O <= |(next_irq_status & irq_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins

  // a serial read borrows the pin only while sharing is clear
  wire pin_src_lock = (pin_src == PIN_SRC_LOCK);
  wire serial_owns  = !pin_share && SERIAL_READ_ACTIVE_I;
  wire next_pin     = serial_owns  ? SERIAL_DATA_I :
                      pin_src_lock ? next_lock : 1'b0;

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      LOCK_OR_SERIAL_OUT_PIN_O <= 1'b0;
    else if (CE_I)
      LOCK_OR_SERIAL_OUT_PIN_O <= next_pin;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      GPO_LOCK_TIMER_CLK_O <= 1'b0;
    else if (CE_I)
      GPO_LOCK_TIMER_CLK_O <= lt_clk;
  end

  // same edge as the internal flag, so pin, status and port agree
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      LOCK_O <= 1'b0;
    else if (CE_I)
      LOCK_O <= next_lock;
  end

endmodule
`default_nettype wire

/* File: logic/plld_lock_timer.sv */
// lock-timer clock divider, visible on the test output
`timescale 1ns/100ps
`default_nettype none
module plld_lock_timer
  import plld_pkg::*;
(
  // clock and control
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire logic                 run_i,
  input  wire logic [LT_RATE_W-1:0] rate_i,
  // timer clock
  output logic                      lt_clk_o
);

  logic [2:0] div_cnt;
  wire  [2:0] half_period_m1 = 3'((4'h1 << rate_i) - 4'h1);
  wire        half_done      = (div_cnt >= half_period_m1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt  <= 3'h0;
      lt_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!run_i)
      begin
        div_cnt  <= 3'h0;
        lt_clk_o <= 1'b0;
      end
      else if (half_done)
      begin
        div_cnt  <= 3'h0;
        lt_clk_o <= ~lt_clk_o;
      end
      else
        div_cnt <= div_cnt + 3'h1;
    end
  end

endmodule
`default_nettype wire

/* File: logic/plld_phase_cmp.sv */
// measures the gap between reference and divided edges against a window
`timescale 1ns/100ps
`default_nettype none
module plld_phase_cmp
  import plld_pkg::*;
(
  // clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             run_i,
  input  wire logic [WIN_W-1:0] window_i,
  // edges at the phase comparator
  input  wire logic             ref_edge_i,
  input  wire logic             vco_edge_i,
  // one result per comparison: an edge pair, or a repeated leading edge
  output logic                  done_o,
  output logic                  inside_o
);

  typedef enum logic [1:0] {IDLE, REF_LEAD, VCO_LEAD} plld_cmp_t;
  plld_cmp_t        state;
  logic [WIN_W-1:0] gap;

  wire gap_ok   = (gap < window_i);
  wire gap_top  = (gap == {WIN_W{1'b1}});

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state    <= IDLE;
      gap      <= '0;
      done_o   <= 1'b0;
      inside_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (!run_i)
      begin
        state <= IDLE;
        gap   <= '0;
      end
      else
      begin
        if (!gap_top)
          gap <= gap + 1'b1;
        unique case (state)
          IDLE:
          begin
            gap <= 11'h001;
            if (ref_edge_i && vco_edge_i)
            begin
              done_o   <= 1'b1;
              inside_o <= 1'b1;
            end
            else if (ref_edge_i)
              state <= REF_LEAD;
            else if (vco_edge_i)
              state <= VCO_LEAD;
          end
          REF_LEAD:
          begin
            if (vco_edge_i)
            begin
              done_o   <= 1'b1;
              inside_o <= gap_ok && !ref_edge_i;
              state    <= IDLE;
            end
            else if (ref_edge_i)
            begin
              done_o   <= 1'b1;
              inside_o <= 1'b0;
              gap      <= 11'h001;
            end
          end
          VCO_LEAD:
          begin
            if (ref_edge_i)
            begin
              done_o   <= 1'b1;
              inside_o <= gap_ok && !vco_edge_i;
              state    <= IDLE;
            end
            else if (vco_edge_i)
            begin
              done_o   <= 1'b1;
              inside_o <= 1'b0;
              gap      <= 11'h001;
            end
          end
          default:
            state <= IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: shared/plld_pkg.sv */
// constants shared by the lock detector design files
package plld_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] LOCK_CFG_IDX   = 8'h07;
  localparam logic [7:0] PIN_CFG_IDX    = 8'h0F;
  localparam logic [7:0] STATUS_IDX     = 8'h12;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_CLEAR_IDX  = 8'h21;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h22;
  localparam int         ADDR_W         = 10;

  // lock configuration fields
  localparam int CNT_TARGET_LSB = 0;
  localparam int CNT_TARGET_W   = 3;
  localparam int LOCK_EN_BIT    = 3;
  localparam int WIN_TYPE_BIT   = 6;
  localparam int WIN_DUR_LSB    = 7;
  localparam int WIN_DUR_W      = 3;
  localparam int LT_RATE_LSB    = 10;
  localparam int LT_RATE_W      = 2;
  localparam logic [31:0] LOCK_CFG_RESET = 32'h0000014D;
  localparam logic [31:0] LOCK_CFG_MASK  = 32'h00000FCF;

  // pin configuration fields
  localparam int PIN_SRC_LSB   = 0;
  localparam int PIN_SRC_W     = 5;
  localparam int PIN_SHARE_BIT = 6;
  localparam logic [31:0] PIN_CFG_RESET = 32'h00000001;
  localparam logic [31:0] PIN_CFG_MASK  = 32'h0000005F;
  localparam logic [4:0]  PIN_SRC_LOCK  = 5'h01;

  // status and interrupt fields
  localparam int STATUS_LOCK_BIT = 1;
  localparam int IRQ_GAINED_BIT  = 0;
  localparam int IRQ_LOST_BIT    = 1;
  localparam int IRQ_W           = 2;

  // timing
  localparam int CLK_MHZ        = 40;
  localparam int ANA_WINDOW_NS  = 10;
  localparam int ANA_WIN_RAW    = ANA_WINDOW_NS * CLK_MHZ / 1000;
  localparam int ANA_WIN_CYC    = (ANA_WIN_RAW < 1) ? 1 : ANA_WIN_RAW;
  localparam int WIN_W          = 11;
  localparam int RUN_W          = 16;

endpackage
